// ---- src/prog_mem_pkg.sv ----
package prog_mem_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          WORD_W        = 16;
  localparam int          DEPTH         = 4096;
  localparam int          DEST_W        = 10;
  localparam logic [11:0] RESET_VECTOR  = 12'h000;
  localparam logic [11:0] LAST_PAGE     = 12'hF00;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  // clocks per instruction cycle of the core
  localparam int          ICYCLE_CLKS   = 4;
  localparam int          TABLE_ICYCLES = 2;
  localparam int          TABLE_CLKS    = ICYCLE_CLKS * TABLE_ICYCLES;
  localparam logic [3:0]  TABLE_LAST    = 4'(TABLE_CLKS - 1);
  // serial frame: op bit, 12 address bits, 16 data bits
  localparam logic [4:0]  LINK_OP_BIT   = 5'h00;
  localparam logic [4:0]  LINK_ADDR_END = 5'h0C;
  localparam logic [4:0]  LINK_LAST_BIT = 5'h1C;

  typedef enum logic {
    TBL_IDLE,
    TBL_BUSY
  } table_state_t;

  typedef struct packed {
    logic              last_page;
    logic              extended;
    logic [DEST_W-1:0] dest;
  } table_req_t;

  typedef struct packed {
    logic [DEST_W-1:0] addr;
    logic [7:0]        data;
  } dm_write_t;
endpackage

// ---- src/program_memory_table_read.sv ----
// What this block does
// - program store of 4K words, 16 bits each, for code and tables.
// - after reset, execution begins at program address 000H.
// - table reads use their own pointer, independent of the program counter.
// - table address is the low pointer byte joined with the low four bits of the high byte.
// - low byte of the read word goes to the operand data location.
// - high byte goes to the high byte latch; missing bits read zero.
// - every table read variant takes two instruction cycles.
// - extended variants reach any sector; normal variants stay in sector 0.
// - last-page variants use page 0F00H and ignore the high pointer byte.
// - software may write the high byte latch to save and restore it.
// - programming moves bits both ways on one data pin, external clock.
// - emulation debug data pin is two-way, clock input, shared uses off.
// - debug pins still serve as the programming pins in emulation.
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read (
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     srst_in,
  // instruction fetch
  input  wire logic                     pc_load_in,
  input  wire logic [11:0]              pc_target_in,
  input  wire logic                     pc_step_in,
  output logic      [11:0]              pc_out,
  output logic      [15:0]              instr_out,
  // table pointer and high byte latch
  input  wire logic                     ptr_low_wr_in,
  input  wire logic                     ptr_high_wr_in,
  input  wire logic [7:0]               ptr_data_in,
  input  wire logic                     table_high_byte_latch_wr_in,
  input  wire logic [7:0]               table_high_byte_latch_data_in,
  output logic      [7:0]               table_high_byte_latch_out,
  // table read request and data memory write
  input  wire logic                     tbl_valid_in,
  input  wire prog_mem_pkg::table_req_t tbl_req_in,
  output logic                          tbl_ready_out,
  output logic                          dm_wr_out,
  output prog_mem_pkg::dm_write_t       dm_write_out,
  // device modes
  input  wire logic                     prog_mode_in,
  input  wire logic                     emulation_in,
  // shared serial pins
  input  wire logic                     prog_serial_data_pin_in,
  output logic                          prog_serial_data_pin_out,
  output logic                          prog_serial_data_pin_oe_n_out,
  input  wire logic                     prog_serial_clock_pin_in,
  // debug engine side of the shared pins
  input  wire logic                     debug_tx_in,
  input  wire logic                     debug_tx_en_in,
  output logic                          debug_serial_data_pin_out,
  output logic                          debug_serial_clock_pin_out,
  // shared general function on the same pins
  input  wire logic                     gpio_data_in,
  input  wire logic                     gpio_oe_n_in,
  output logic                          gpio_data_out,
  output logic                          gpio_clock_out
);
  import prog_mem_pkg::*;

  localparam int TBL_DONE = TABLE_CLKS;

  logic [WORD_W-1:0] mem [DEPTH];

  logic [11:0]       pc;
  logic [7:0]        ptr_low;
  logic [7:0]        ptr_high;
  logic [7:0]        table_high_byte_latch;
  table_state_t      state;
  logic [3:0]        tcount;
  table_req_t        req;
  logic [11:0]       tbl_addr;
  logic [15:0]       tbl_word;
  logic              clk_q;
  logic [4:0]        bit_cnt;
  logic              link_op_read;
  logic [11:0]       link_addr;
  logic [15:0]       link_shift;
  logic              link_load;

  wire  [11:0] ptr_full    = {ptr_high[3:0], ptr_low};
  wire  [11:0] ptr_page    = {LAST_PAGE[11:8], ptr_low};
  wire  [11:0] next_addr   = tbl_req_in.last_page ? ptr_page : ptr_full;
  wire         accept      = tbl_valid_in & tbl_ready_out;
  wire         tbl_end     = (state == TBL_BUSY) && (tcount == TABLE_LAST);
  wire  [DEST_W-1:0] dest  = req.extended ? req.dest
                           : {{(DEST_W-8){1'b0}}, req.dest[7:0]};
  wire         link_rise   = prog_mode_in & prog_serial_clock_pin_in & ~clk_q;
  wire         link_drive  = prog_mode_in & link_op_read
                           & (bit_cnt > LINK_ADDR_END);
  wire         link_wr     = link_rise & ~link_op_read
                           & (bit_cnt == LINK_LAST_BIT);
  wire  [11:0] next_pc     = pc_load_in ? pc_target_in
                           : pc_step_in ? 12'(pc + 12'h001) : pc;

  // reads of the table are refused during programming
  assign tbl_ready_out = (state == TBL_IDLE) & ~prog_mode_in;
  assign pc_out        = pc;
  assign table_high_byte_latch_out = table_high_byte_latch;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      pc        <= RESET_VECTOR;
      instr_out <= WORD_RESET;
    end else begin
      pc        <= next_pc;
      instr_out <= mem[pc];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ptr_low  <= BYTE_RESET;
      ptr_high <= BYTE_RESET;
    end else begin
      if (ptr_low_wr_in) ptr_low <= ptr_data_in;
      if (ptr_high_wr_in) ptr_high <= ptr_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state    <= TBL_IDLE;
      tcount   <= 4'h0;
      req      <= '0;
      tbl_addr <= RESET_VECTOR;
      tbl_word <= WORD_RESET;
    end else begin
      tbl_word <= mem[tbl_addr];
      case (state)
        TBL_IDLE: begin
          tcount <= 4'h0;
          if (accept) begin
            req      <= tbl_req_in;
            tbl_addr <= next_addr;
            state    <= TBL_BUSY;
          end
        end
        TBL_BUSY: begin
          tcount <= 4'(tcount + 4'h1);
          if (tbl_end) state <= TBL_IDLE;
        end
        default: state <= TBL_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      dm_wr_out    <= 1'b0;
      dm_write_out <= '0;
    end else begin
      dm_wr_out <= tbl_end;
      if (tbl_end) dm_write_out <= '{addr: dest, data: tbl_word[7:0]};
    end
  end

  // high byte latch, table load wins over software write
  always_ff @(posedge mclk_in) begin
    if (srst_in) table_high_byte_latch <= BYTE_RESET;
    else if (tbl_end) table_high_byte_latch <= tbl_word[15:8];
    else if (table_high_byte_latch_wr_in) table_high_byte_latch <= table_high_byte_latch_data_in;
  end

  // serial frame, sampled on the programmer clock rising edge
  always_ff @(posedge mclk_in) begin
    if (srst_in || !prog_mode_in) begin
      clk_q        <= 1'b0;
      bit_cnt      <= LINK_OP_BIT;
      link_op_read <= 1'b0;
      link_addr    <= RESET_VECTOR;
      link_shift   <= WORD_RESET;
      link_load    <= 1'b0;
    end else begin
      clk_q     <= prog_serial_clock_pin_in;
      link_load <= link_rise & (bit_cnt == LINK_ADDR_END);
      if (link_load) link_shift <= mem[link_addr];
      if (link_rise) begin
        bit_cnt <= (bit_cnt == LINK_LAST_BIT) ? LINK_OP_BIT
                 : 5'(bit_cnt + 5'h01);
        if (bit_cnt == LINK_OP_BIT) link_op_read <= prog_serial_data_pin_in;
        else if (bit_cnt <= LINK_ADDR_END)
          link_addr <= {link_addr[10:0], prog_serial_data_pin_in};
        else if (link_op_read && bit_cnt > LINK_ADDR_END)
          link_shift <= {link_shift[14:0], 1'b0};
        else if (!link_op_read)
          link_shift <= {link_shift[14:0], prog_serial_data_pin_in};
      end
    end
  end

  // the word lands in memory only once its sixteenth bit is in
  always_ff @(posedge mclk_in) begin
    if (link_wr) mem[link_addr] <= {link_shift[14:0], prog_serial_data_pin_in};
  end

  // programming owns the pins, shared uses released
  // debug drive in emulation, shared function inactive
  assign prog_serial_data_pin_out     = prog_mode_in ? link_shift[15]
                                      : emulation_in ? debug_tx_in
                                      : gpio_data_in;
  assign prog_serial_data_pin_oe_n_out = prog_mode_in ? ~link_drive
                                      : emulation_in ? ~debug_tx_en_in
                                      : gpio_oe_n_in;
  wire   shared_off                   = prog_mode_in | emulation_in;
  assign debug_serial_data_pin_out    = emulation_in & ~prog_mode_in
                                      & prog_serial_data_pin_in;
  assign debug_serial_clock_pin_out   = emulation_in & ~prog_mode_in
                                      & prog_serial_clock_pin_in;
  assign gpio_data_out                = ~shared_off & prog_serial_data_pin_in;
  assign gpio_clock_out               = ~shared_off & prog_serial_clock_pin_in;

  a_reset_vector: assert property (@(posedge mclk_in)
    srst_in |=> pc_out == 12'h000) else $error("pc not at reset vector");
  a_table_latency: assert property (@(posedge mclk_in)
    disable iff (srst_in) accept |=> ##TBL_DONE dm_wr_out)
    else $error("table read not 2 cycles");
  a_no_early_done: assert property (@(posedge mclk_in)
    disable iff (srst_in) accept |=> !dm_wr_out [*8])
    else $error("table read done too early");
  a_low_byte: assert property (@(posedge mclk_in) disable iff (srst_in)
    dm_wr_out |-> dm_write_out.data == $past(tbl_word[7:0]))
    else $error("wrong low byte");
  a_high_byte: assert property (@(posedge mclk_in) disable iff (srst_in)
    dm_wr_out |-> table_high_byte_latch == $past(tbl_word[15:8])) else $error("wrong table_high_byte_latch");
  a_last_page: assert property (@(posedge mclk_in) disable iff (srst_in)
    accept && tbl_req_in.last_page |=> tbl_addr == {4'hF, $past(ptr_low)})
    else $error("last page address wrong");
  a_joined_ptr: assert property (@(posedge mclk_in) disable iff (srst_in)
    accept && !tbl_req_in.last_page
    |=> tbl_addr == {$past(ptr_high[3:0]), $past(ptr_low)})
    else $error("pointer address wrong");
  a_sector_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
    dm_wr_out && !req.extended |-> dm_write_out.addr[9:8] == 2'b00)
    else $error("normal read left sector 0");
  a_table_high_byte_latch_write: assert property (@(posedge mclk_in) disable iff (srst_in)
    table_high_byte_latch_wr_in && !tbl_end |=> table_high_byte_latch == $past(table_high_byte_latch_data_in))
    else $error("table_high_byte_latch write lost");
  a_shared_off: assert property (@(posedge mclk_in) disable iff (srst_in)
    emulation_in |-> !gpio_data_out && !gpio_clock_out)
    else $error("shared function active in emulation");
  a_prog_owns: assert property (@(posedge mclk_in) disable iff (srst_in)
    prog_mode_in && !link_drive |-> prog_serial_data_pin_oe_n_out)
    else $error("pin driven while receiving");

  c_table_read: cover property (@(posedge mclk_in) accept ##9 dm_wr_out);
  c_last_page: cover property (@(posedge mclk_in)
    accept && tbl_req_in.last_page);
  c_extended: cover property (@(posedge mclk_in) dm_wr_out && req.extended);
  c_link_write: cover property (@(posedge mclk_in) link_wr);
endmodule
`default_nettype wire

// ---- verification/table_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module table_core_model (
  // clock and design handshake
  input  wire logic                     mclk_in,
  input  wire logic                     tbl_ready_in,
  input  wire logic                     dm_wr_in,
  // pointer and request drive
  output logic                          ptr_low_wr_out,
  output logic                          ptr_high_wr_out,
  output logic [7:0]                    ptr_data_out,
  output logic                          tbl_valid_out,
  output prog_mem_pkg::table_req_t      tbl_req_out
);
  import prog_mem_pkg::*;

  initial begin
    ptr_low_wr_out = 1'b0;
    ptr_high_wr_out = 1'b0;
    ptr_data_out = 8'h00;
    tbl_valid_out = 1'b0;
    tbl_req_out = '0;
  end

  // n is -1 when the answer never came
  task automatic table_read(input logic [7:0] hi, input logic [7:0] lo,
                            input table_req_t rq, output int n);
    n = -1;
    @(negedge mclk_in);
    ptr_data_out = hi;
    ptr_high_wr_out = 1'b1;
    @(negedge mclk_in);
    ptr_high_wr_out = 1'b0;
    ptr_data_out = lo;
    ptr_low_wr_out = 1'b1;
    @(negedge mclk_in);
    ptr_low_wr_out = 1'b0;
    tbl_req_out = rq;
    tbl_valid_out = 1'b1;
    for (int i = 0; i < 20 && tbl_ready_in !== 1'b1; i++) begin
      @(negedge mclk_in);
    end
    @(negedge mclk_in);
    tbl_valid_out = 1'b0;
    for (int i = 0; i < 20; i++) begin
      if (dm_wr_in === 1'b1 && n < 0) begin
        n = i;
      end
      if (n < 0) begin
        @(negedge mclk_in);
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import prog_mem_pkg::*;
  logic mclk = 0, srst = 1, pc_load = 0, pc_step = 0, table_high_byte_latch_wr = 0;
  logic prog_mode = 0, emul = 0, clk_pin = 0, drv = 1, drv_en = 0;
  logic dtx = 0, dtx_en = 0, ptr_lw, ptr_hw, valid, ready, dm_wr;
  logic gp_di = 0, gp_oe_n = 0;
  logic oe_n, dout, pin, dbg_d, dbg_c, gp_d, gp_c;
  logic [11:0] pc_target = 0, pc;
  logic [7:0] table_high_byte_latch_data = 0, ptr_d, table_high_byte_latch;
  logic [15:0] instr, rd;
  table_req_t req;
  dm_write_t dmw;
  int miscompares = 0, cmp_count = 0, n;

  initial begin
    forever #4 mclk = ~mclk;
  end
  // pull-up holds the data line when nobody drives it
  assign pin = !oe_n ? dout : (drv_en ? drv : 1'b1);

  program_memory_table_read uut (.mclk_in(mclk), .srst_in(srst),
    .pc_load_in(pc_load), .pc_target_in(pc_target), .pc_step_in(pc_step),
    .pc_out(pc), .instr_out(instr), .ptr_low_wr_in(ptr_lw),
    .ptr_high_wr_in(ptr_hw), .ptr_data_in(ptr_d), .table_high_byte_latch_wr_in(table_high_byte_latch_wr),
    .table_high_byte_latch_data_in(table_high_byte_latch_data), .table_high_byte_latch_out(table_high_byte_latch),
    .tbl_valid_in(valid), .tbl_req_in(req), .tbl_ready_out(ready),
    .dm_wr_out(dm_wr), .dm_write_out(dmw), .prog_mode_in(prog_mode),
    .emulation_in(emul), .prog_serial_data_pin_in(pin),
    .prog_serial_data_pin_out(dout), .prog_serial_data_pin_oe_n_out(oe_n),
    .prog_serial_clock_pin_in(clk_pin), .debug_tx_in(dtx),
    .debug_tx_en_in(dtx_en), .debug_serial_data_pin_out(dbg_d),
    .debug_serial_clock_pin_out(dbg_c), .gpio_data_in(gp_di),
    .gpio_oe_n_in(gp_oe_n), .gpio_data_out(gp_d), .gpio_clock_out(gp_c));

  table_core_model core (.mclk_in(mclk), .tbl_ready_in(ready),
    .dm_wr_in(dm_wr), .ptr_low_wr_out(ptr_lw), .ptr_high_wr_out(ptr_hw),
    .ptr_data_out(ptr_d), .tbl_valid_out(valid), .tbl_req_out(req));

  task check(input logic [15:0] got, input logic [15:0] exp, input string s);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // fixed frame: op, 12 address bits, 16 data bits, msb first
  task automatic link_frame(input logic op, input logic [11:0] a,
                            input logic [15:0] d);
    logic [28:0] f;
    f = {op, a, d};
    rd = '0;
    @(negedge mclk);
    prog_mode = 1;
    for (int i = 0; i < 29; i++) begin
      @(negedge mclk);
      drv = f[28-i];
      drv_en = !(op && i >= 13);
      if (op && i >= 13) begin
        rd = {rd[14:0], pin};
      end
      @(negedge mclk);
      clk_pin = 1;
      repeat (2) @(negedge mclk);
      clk_pin = 0;
      repeat (2) @(negedge mclk);
    end
    drv_en = 0;
    prog_mode = 0;
  endtask

  task automatic table_case(input logic [7:0] hi, input logic [7:0] lo,
    input table_req_t rq, input logic [9:0] ea, input logic [15:0] ew);
    core.table_read(hi, lo, rq, n);
    if (n < 0) begin
      miscompares++;
      end_of_test;
    end
    check(16'(n), 16'(TABLE_CLKS), "cycles");
    check(16'(dmw.addr), 16'(ea), "dest");
    check(16'(dmw.data), 16'(ew[7:0]), "low byte");
    check(16'(table_high_byte_latch), 16'(ew[15:8]), "high byte");
    $display("table read %h%h done", hi, lo);
  endtask

  initial begin
    repeat (20) @(negedge mclk);
    srst = 0;
    check(16'(pc), 16'(RESET_VECTOR), "pc");
    check(16'(table_high_byte_latch), 16'h0000, "latch");
    check(16'(dm_wr), 16'h0000, "dm write");
    $display("reset done");
    link_frame(0, 12'h345, 16'hA55A);
    emul = 1;
    link_frame(0, 12'hF06, 16'h001A);
    emul = 0;
    prog_mode = 1;
    @(negedge mclk);
    check(16'(ready), 16'h0000, "ready in prog");
    link_frame(1, 12'h345, 16'h0000);
    check(rd, 16'hA55A, "link read");
    $display("link done");
    // high pointer bits beyond 12 ignored
    table_case(8'hF3, 8'h45, {1'b0, 1'b0, 10'h3C5}, 10'h0C5, 16'hA55A);
    // last page ignores the high pointer byte
    table_case(8'h03, 8'h06, {1'b1, 1'b1, 10'h2AB}, 10'h2AB, 16'h001A);
    @(negedge mclk);
    table_high_byte_latch_data = 8'h77;
    table_high_byte_latch_wr = 1;
    @(negedge mclk);
    table_high_byte_latch_wr = 0;
    check(16'(table_high_byte_latch), 16'h0077, "latch write");
    pc_target = 12'hF06;
    pc_load = 1;
    @(negedge mclk);
    pc_load = 0;
    pc_step = 1;
    check(16'(pc), 16'h0F06, "pc load");
    @(negedge mclk);
    pc_step = 0;
    check(16'(pc), 16'h0F07, "pc step");
    check(instr, 16'h001A, "fetch");
    $display("fetch done");
    emul = 1;
    clk_pin = 1;
    @(negedge mclk);
    check(16'(oe_n), 16'h0001, "shared drive off");
    dtx = 1;
    dtx_en = 1;
    @(negedge mclk);
    check(16'({oe_n, dbg_d}), 16'h0001, "debug drive");
    check(16'({dbg_c, gp_d, gp_c}), 16'h0004, "shared off");
    $display("debug done");
    end_of_test;
  end
endmodule
`default_nettype wire
